// ==== rtsf_defines.svh ====
// Constants of the 128-bit receive stream framer
`ifndef RTSF_DEFINES_SVH
`define RTSF_DEFINES_SVH

`define RTSF_DATA_W 128
`define RTSF_QW_W 64
`define RTSF_USER_W 22
`define RTSF_SOF_LSB 10
`define RTSF_SOF_MSB 14
`define RTSF_EOF_LSB 17
`define RTSF_EOF_MSB 21
`define RTSF_FLAG_BIT 4
`define RTSF_MARK_NONE 5'h00
`define RTSF_SOF_BYTE0 5'h10
`define RTSF_SOF_BYTE8 5'h18
`define RTSF_EOF_LOW 2'h3
`define RTSF_TUSER_RST 22'h000000
`define RTSF_DATA_RST 128'h0
`define RTSF_QW_ZERO 64'h0
`define RTSF_FIFO_DEPTH 2

`endif

// ==== rtsf_pkg.sv ====
// Types shared by the receive stream framer modules
package rtsf_pkg;

  // One ingress word: up to four DWORDs of one packet, DWORD 0 lowest
  typedef struct packed {
    logic [127:0] data;
    logic sop;
    logic eop;
    logic [1:0] last;
  } rtsf_word_t;

  // Gray order along align -> shift -> flush
  typedef enum logic [1:0] {
    RTSF_ST_ALIGN = 2'b00,
    RTSF_ST_SHIFT = 2'b01,
    RTSF_ST_FLUSH = 2'b11
  } rtsf_state_t;

endpackage : rtsf_pkg

// ==== rtsf_ingress_if.sv ====
// Peek and pop channel between ingress buffer and framer
`timescale 1ns/1ps
interface rtsf_ingress_if;
  import rtsf_pkg::*;
  rtsf_word_t head;
  rtsf_word_t next;
  logic head_vld;
  logic next_vld;
  logic [1:0] pop;

  modport fifo (
    output head,
    output next,
    output head_vld,
    output next_vld,
    input pop
  );

  modport framer (
    input head,
    input next,
    input head_vld,
    input next_vld,
    output pop
  );
endinterface : rtsf_ingress_if

// ==== rtsf_ingress.sv ====
// Two-entry ingress buffer with two-word peek and pop of up to two
`timescale 1ns/1ps
`include "rtsf_defines.svh"
module rtsf_ingress
  import rtsf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire rtsf_word_t wr_word_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  rtsf_ingress_if.fifo rd
);
  localparam int DEPTH = `RTSF_FIFO_DEPTH;

  rtsf_word_t mem_ff [DEPTH];
  logic rd_ff;
  logic [1:0] count_ff;
  logic ready_ff;
  logic nxt_rd;
  logic [1:0] nxt_count;
  logic nxt_ready;
  logic push;
  logic wr_idx;

  assign push = wr_valid_i && ready_ff;
  // Tail slot is fixed by the current head and fill, whatever is popped
  assign wr_idx = rd_ff ^ count_ff[0];
  assign wr_ready_o = ready_ff;
  assign rd.head = mem_ff[rd_ff];
  assign rd.next = mem_ff[~rd_ff];
  assign rd.head_vld = (count_ff != 2'd0);
  assign rd.next_vld = (count_ff == 2'd2);

  always_comb begin
    nxt_rd = rd_ff ^ rd.pop[0];
    nxt_count = count_ff - rd.pop + {1'b0, push};
    // Registered ready: space for one word on the next edge
    nxt_ready = (nxt_count < 2'd2);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_ff <= 1'b0;
      count_ff <= 2'd0;
      ready_ff <= 1'b0;
    end else begin
      rd_ff <= nxt_rd;
      count_ff <= nxt_count;
      ready_ff <= nxt_ready;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk_i) begin
      if (push && (wr_idx == 1'(i))) begin
        mem_ff[i] <= wr_word_i;
      end
    end
  end
endmodule : rtsf_ingress

// ==== rtsf_framer.sv ====
// Receive stream framer: packs packet words into 128-bit marked beats
`timescale 1ns/1ps
`include "rtsf_defines.svh"
module rtsf_framer
  import rtsf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [127:0] pkt_data_i,
  input wire logic pkt_valid_i,
  input wire logic pkt_sop_i,
  input wire logic pkt_eop_i,
  input wire logic [1:0] pkt_last_dw_i,
  output logic pkt_ready_o,
  output logic [127:0] m_axis_rx_tdata_o,
  output logic m_axis_rx_tvalid_o,
  output logic [21:0] m_axis_rx_tuser_o,
  input wire logic m_axis_rx_tready_i
);
  rtsf_ingress_if ing ();
  rtsf_word_t wr_word;

  rtsf_state_t state_ff;
  rtsf_state_t nxt_state;
  logic [63:0] carry_ff;
  logic [63:0] nxt_carry;
  logic clast_ff;
  logic nxt_clast;
  logic [127:0] tdata_ff;
  logic [127:0] nxt_tdata;
  logic tvalid_ff;
  logic nxt_tvalid;
  logic [21:0] tuser_ff;
  logic [21:0] nxt_tuser;
  logic [4:0] nxt_sof;
  logic [4:0] nxt_eof;
  logic [1:0] pop;
  logic adv;

  assign wr_word = '{data: pkt_data_i, sop: pkt_sop_i, eop: pkt_eop_i,
                     last: pkt_last_dw_i};

  // Upstream stalls through this buffer once a beat held by a low tready has let both entries fill
  rtsf_ingress u_ingress (
    .core_clk_i (core_clk_i),
    .srst_i (srst_i),
    .wr_word_i (wr_word),
    .wr_valid_i (pkt_valid_i),
    .wr_ready_o (pkt_ready_o),
    .rd (ing.fifo)
  );

  assign ing.pop = pop;
  // Output beat may be replaced only once taken or when empty
  assign adv = !tvalid_ff || m_axis_rx_tready_i;

  always_comb begin
    nxt_state = state_ff;
    nxt_carry = carry_ff;
    nxt_clast = clast_ff;
    nxt_tdata = tdata_ff;
    nxt_tvalid = tvalid_ff;
    nxt_sof = tuser_ff[`RTSF_SOF_MSB:`RTSF_SOF_LSB];
    nxt_eof = tuser_ff[`RTSF_EOF_MSB:`RTSF_EOF_LSB];
    pop = 2'd0;
    if (adv) begin
      // Empty slot drops valid and both flags
      nxt_tvalid = 1'b0;
      nxt_sof = `RTSF_MARK_NONE;
      nxt_eof = `RTSF_MARK_NONE;
      case (state_ff)
        RTSF_ST_ALIGN: begin
          if (ing.head_vld) begin
            pop = 2'd1;
            nxt_tvalid = 1'b1;
            nxt_tdata = ing.head.data;
            nxt_sof = ing.head.sop ? `RTSF_SOF_BYTE0 : `RTSF_MARK_NONE;
            nxt_eof = ing.head.eop ?
              {1'b1, ing.head.last, `RTSF_EOF_LOW} : `RTSF_MARK_NONE;
            // Lower-QWORD end with next packet already waiting: straddle
            if (ing.head.eop && !ing.head.last[1] && ing.next_vld &&
                ing.next.sop) begin
              pop = 2'd2;
              nxt_tdata[127:64] = ing.next.data[63:0];
              nxt_sof = `RTSF_SOF_BYTE8;
              nxt_carry = ing.next.data[127:64];
              nxt_clast = ing.next.last[0];
              // Three DWORDs minimum: the new packet cannot also end here
              nxt_state = ing.next.eop ? RTSF_ST_FLUSH : RTSF_ST_SHIFT;
            end
          end
        end
        RTSF_ST_SHIFT: begin
          // Relies on upstream delivering a started packet without gaps
          if (ing.head_vld) begin
            pop = 2'd1;
            nxt_tvalid = 1'b1;
            nxt_tdata = {ing.head.data[63:0], carry_ff};
            nxt_carry = ing.head.data[127:64];
            nxt_clast = ing.head.last[0];
            if (ing.head.eop && !ing.head.last[1]) begin
              nxt_eof = {2'b11, ing.head.last[0], `RTSF_EOF_LOW};
              nxt_state = RTSF_ST_ALIGN;
            end else if (ing.head.eop) begin
              nxt_state = RTSF_ST_FLUSH;
            end
          end
        end
        RTSF_ST_FLUSH: begin
          nxt_tvalid = 1'b1;
          nxt_tdata = {`RTSF_QW_ZERO, carry_ff};
          nxt_eof = {2'b10, clast_ff, `RTSF_EOF_LOW};
          nxt_state = RTSF_ST_ALIGN;
          if (ing.head_vld && ing.head.sop) begin
            pop = 2'd1;
            nxt_tdata[127:64] = ing.head.data[63:0];
            nxt_sof = `RTSF_SOF_BYTE8;
            nxt_carry = ing.head.data[127:64];
            nxt_clast = ing.head.last[0];
            nxt_state = ing.head.eop ? RTSF_ST_FLUSH : RTSF_ST_SHIFT;
          end
        end
        default: begin
          nxt_state = RTSF_ST_ALIGN;
        end
      endcase
    end
    nxt_tuser = `RTSF_TUSER_RST;
    nxt_tuser[`RTSF_SOF_MSB:`RTSF_SOF_LSB] = nxt_sof;
    nxt_tuser[`RTSF_EOF_MSB:`RTSF_EOF_LSB] = nxt_eof;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= RTSF_ST_ALIGN;
      carry_ff <= `RTSF_QW_ZERO;
      clast_ff <= 1'b0;
      tdata_ff <= `RTSF_DATA_RST;
      tvalid_ff <= 1'b0;
      tuser_ff <= `RTSF_TUSER_RST;
    end else begin
      state_ff <= nxt_state;
      carry_ff <= nxt_carry;
      clast_ff <= nxt_clast;
      tdata_ff <= nxt_tdata;
      tvalid_ff <= nxt_tvalid;
      tuser_ff <= nxt_tuser;
    end
  end

  assign m_axis_rx_tdata_o = tdata_ff;
  assign m_axis_rx_tvalid_o = tvalid_ff;
  assign m_axis_rx_tuser_o = tuser_ff;

  // Checking helpers: open packet tracking on the output side
  logic [4:0] sof_mk;
  logic [4:0] eof_mk;
  logic xfer;
  logic in_pkt_ff;
  logic nxt_in_pkt;

  assign sof_mk = tuser_ff[`RTSF_SOF_MSB:`RTSF_SOF_LSB];
  assign eof_mk = tuser_ff[`RTSF_EOF_MSB:`RTSF_EOF_LSB];
  assign xfer = tvalid_ff && m_axis_rx_tready_i;

  always_comb begin
    nxt_in_pkt = in_pkt_ff;
    if (xfer && sof_mk[4]) begin
      nxt_in_pkt = !eof_mk[4] || (sof_mk == `RTSF_SOF_BYTE8);
    end else if (xfer && eof_mk[4]) begin
      nxt_in_pkt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      in_pkt_ff <= 1'b0;
    end else begin
      in_pkt_ff <= nxt_in_pkt;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_SOF_LOW_ZERO: assert property (
    tvalid_ff && sof_mk[4] |-> sof_mk[2:0] == 3'h0)
    else $error("start marker low bits not zero");

  AST_EOF_LOW_ONES: assert property (
    tvalid_ff && eof_mk[4] |-> eof_mk[1:0] == 2'h3)
    else $error("end marker low bits not ones");

  AST_HOLD_STALL: assert property (
    tvalid_ff && !m_axis_rx_tready_i |=> tvalid_ff && $stable(tdata_ff)
      && $stable(tuser_ff))
    else $error("beat changed while stalled");

  AST_RESET_QUIET: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
      srst_i |=> !tvalid_ff && !sof_mk[4] && !eof_mk[4])
    else $error("valid or flag raised after reset");

  AST_STRADDLE_CODES: assert property (
    tvalid_ff && sof_mk[4] && eof_mk[4] && sof_mk[3] |->
      !eof_mk[3] && in_pkt_ff)
    else $error("straddle codes wrong");

  AST_SINGLE_BEAT: assert property (
    tvalid_ff && sof_mk == `RTSF_SOF_BYTE0 && eof_mk[4] |->
      eof_mk[3] && !in_pkt_ff)
    else $error("single beat packet end code wrong");

  AST_ONE_START: assert property (
    tvalid_ff && sof_mk[4] && !(eof_mk[4] && sof_mk[3]) |-> !in_pkt_ff)
    else $error("start inside an open packet");

  AST_END_HAS_PKT: assert property (
    tvalid_ff && eof_mk[4] && !sof_mk[4] |-> in_pkt_ff)
    else $error("end without an open packet");

  AST_FLUSH_ENDS: assert property (
    state_ff == RTSF_ST_FLUSH && adv |=> tvalid_ff && eof_mk[4]
      && !eof_mk[3] ##1 1'b1)
    else $error("flush beat without lower end code");

  // AST_NO_GAP and AST_START_CLEARS below lean on upstream sending a started packet without gaps

  // Idle slot carries no stray markers
  AST_IDLE_QUIET: assert property (
    !tvalid_ff |-> sof_mk == `RTSF_MARK_NONE && eof_mk == `RTSF_MARK_NONE)
    else $error("markers set while tvalid low");

  // Open packet keeps a beat on offer
  AST_NO_GAP: assert property (
    in_pkt_ff |-> tvalid_ff)
    else $error("tvalid dropped inside a packet");

  // Next beat of a multi-beat packet cannot restart at byte 0
  AST_START_CLEARS: assert property (
    xfer && sof_mk[4] && !eof_mk[4] |=> tvalid_ff
      && sof_mk != `RTSF_SOF_BYTE0)
    else $error("start flag repeated inside a packet");

  // Only the two QWORD-aligned start codes exist
  AST_SOF_CODE: assert property (
    tvalid_ff && sof_mk[4] |->
      sof_mk == `RTSF_SOF_BYTE0 || sof_mk == `RTSF_SOF_BYTE8)
    else $error("start code not byte 0 or byte 8");

  // First beat of a long packet starts at QWORD boundary
  AST_MULTI_FIRST: assert property (
    tvalid_ff && sof_mk[4] && !eof_mk[4] |->
      sof_mk[3:0] == 4'h0 || sof_mk[3:0] == 4'h8)
    else $error("multi-beat start code wrong");

  // An unstraddled end closes the packet
  AST_END_CLOSES: assert property (
    xfer && eof_mk[4] && sof_mk != `RTSF_SOF_BYTE8 |=> !in_pkt_ff)
    else $error("packet still open after its end");

  // Flush beat leaves the upper QWORD zero unless a straddle fills it
  AST_FLUSH_UPPER: assert property (
    state_ff == RTSF_ST_FLUSH && adv |=>
      sof_mk[4] || tdata_ff[127:64] == `RTSF_QW_ZERO)
    else $error("flush beat upper QWORD not zero");

  // Buffered next start after a lower end must straddle
  AST_STRADDLE_FORMS: assert property (
    state_ff == RTSF_ST_ALIGN && adv && ing.head_vld && ing.head.eop
      && !ing.head.last[1] && ing.next_vld && ing.next.sop
      |=> sof_mk == `RTSF_SOF_BYTE8)
    else $error("straddle not formed");

  // Scenario coverage
  COV_FLUSH_STRADDLE: cover property (
    state_ff == RTSF_ST_FLUSH && adv && ing.head_vld && ing.head.sop);
  COV_SINGLE: cover property (
    xfer && sof_mk == `RTSF_SOF_BYTE0 && eof_mk[4]);
  COV_STRADDLE: cover property (xfer && sof_mk[3] && eof_mk[4]);
  COV_STALL: cover property (tvalid_ff && !m_axis_rx_tready_i [*3]);
  COV_BACK2BACK: cover property (
    xfer && eof_mk[4] ##1 xfer && sof_mk == `RTSF_SOF_BYTE0);
endmodule : rtsf_framer

// ==== rtsf_user_sink.sv ====
// User-side sink model: throttles tready and records accepted beats
`timescale 1ns/1ps
module rtsf_user_sink (
  input wire logic core_clk_i,
  input wire logic [127:0] tdata_i,
  input wire logic tvalid_i,
  input wire logic [21:0] tuser_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic tready_o
);
  logic [127:0] data_q[$];
  logic [21:0] user_q[$];
  logic phase_ff;

  initial begin
    tready_o = 1'b0;
    phase_ff = 1'b0;
  end

  always @(posedge core_clk_i) begin
    // Fields mean nothing unless valid and ready meet
    if (tvalid_i && tready_o) begin
      data_q.push_back(tdata_i);
      user_q.push_back(tuser_i);
    end
    phase_ff <= ~phase_ff;
    tready_o <= ~stall_i && (~slow_i || phase_ff);
  end
endmodule : rtsf_user_sink

// ==== rx_tlp_stream_framing_128_tb.sv ====
// Testbench for the receive stream framer
`timescale 1ns/1ps
module rx_tlp_stream_framing_128_tb;
  import rtsf_pkg::*;
  logic core_clk_i;
  logic srst_i = 1'b1;
  logic [127:0] pkt_data_i = 128'h0;
  logic pkt_valid_i = 1'b0;
  logic pkt_sop_i = 1'b0;
  logic pkt_eop_i = 1'b0;
  logic [1:0] pkt_last_dw_i = 2'h0;
  logic pkt_ready_o;
  logic [127:0] tdata;
  logic tvalid;
  logic [21:0] tuser;
  logic tready;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  rtsf_word_t src_q[$];
  logic [127:0] exp_d[$];
  logic [21:0] exp_u[$];

  rtsf_framer u_rtsf_framer (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .pkt_data_i(pkt_data_i), .pkt_valid_i(pkt_valid_i),
    .pkt_sop_i(pkt_sop_i), .pkt_eop_i(pkt_eop_i),
    .pkt_last_dw_i(pkt_last_dw_i), .pkt_ready_o(pkt_ready_o),
    .m_axis_rx_tdata_o(tdata), .m_axis_rx_tvalid_o(tvalid),
    .m_axis_rx_tuser_o(tuser), .m_axis_rx_tready_i(tready));

  rtsf_user_sink u_rtsf_user_sink (.core_clk_i(core_clk_i),
    .tdata_i(tdata), .tvalid_i(tvalid), .tuser_i(tuser),
    .stall_i(stall), .slow_i(slow), .tready_o(tready));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic chk(string what, logic [127:0] e, logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  function automatic logic [127:0] pat(logic [31:0] n);
    return {n + 32'h3, n + 32'h2, n + 32'h1, n};
  endfunction : pat

  task automatic put(logic [127:0] d, logic s, logic e, logic [1:0] l);
    src_q.push_back('{data: d, sop: s, eop: e, last: l});
  endtask : put

  task automatic want(logic [127:0] d, logic [4:0] sof, logic [4:0] eof);
    exp_d.push_back(d);
    exp_u.push_back({eof, 2'h0, sof, 10'h000});
  endtask : want

  // Holds each word until a ready edge takes it
  task automatic send();
    foreach (src_q[i]) begin
      pkt_data_i <= src_q[i].data;
      pkt_sop_i <= src_q[i].sop;
      pkt_eop_i <= src_q[i].eop;
      pkt_last_dw_i <= src_q[i].last;
      pkt_valid_i <= 1'b1;
      @(negedge core_clk_i);
      while (pkt_ready_o !== 1'b1) @(negedge core_clk_i);
      @(posedge core_clk_i);
    end
    pkt_valid_i <= 1'b0;
    src_q.delete();
  endtask : send

  task automatic drain(string name);
    logic [127:0] m;
    logic [21:0] u;
    int w;
    w = 0;
    do begin
      @(negedge core_clk_i);
      w++;
    end while (u_rtsf_user_sink.data_q.size() < exp_d.size() && w < 300);
    chk("beats", 128'(exp_d.size()), 128'(u_rtsf_user_sink.data_q.size()));
    foreach (exp_d[i]) begin
      if (i < u_rtsf_user_sink.data_q.size()) begin
        u = exp_u[i];
        // Invalid DWORDs above the end carry no promise
        m = u[21] ? ~128'h0 >> (32 * (3 - int'(u[20:19]))) : ~128'h0;
        if (u[13]) m = m | {~64'h0, 64'h0};
        chk("tdata", exp_d[i] & m, u_rtsf_user_sink.data_q[i] & m);
        chk("tuser", 128'(u), 128'(u_rtsf_user_sink.user_q[i]));
      end
    end
    chk("tvalid idle", 128'h0, 128'(tvalid));
    exp_d.delete();
    exp_u.delete();
    u_rtsf_user_sink.data_q.delete();
    u_rtsf_user_sink.user_q.delete();
    $display("test %s done", name);
    @(posedge core_clk_i);
  endtask : drain

  task automatic t_reset();
    repeat (3) begin
      @(negedge core_clk_i);
      chk("tvalid", 128'h0, 128'(tvalid));
      chk("tuser", 128'h0, 128'(tuser));
    end
    @(posedge core_clk_i);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single();
    put(pat(32'h100), 1'b1, 1'b1, 2'h2);
    put(pat(32'h200), 1'b1, 1'b1, 2'h3);
    want(pat(32'h100), 5'h10, 5'h1B);
    want(pat(32'h200), 5'h10, 5'h1F);
    send();
    drain("single");
  endtask : t_single

  task automatic t_multi(logic [1:0] k);
    slow <= k[0];
    put(pat(32'h300), 1'b1, 1'b0, 2'h3);
    put(pat(32'h304), 1'b0, 1'b0, 2'h3);
    put(pat(32'h308), 1'b0, 1'b1, k);
    want(pat(32'h300), 5'h10, 5'h00);
    want(pat(32'h304), 5'h00, 5'h00);
    want(pat(32'h308), 5'h00, {1'b1, k, 2'h3});
    send();
    drain("multi");
  endtask : t_multi

  task automatic t_straddle(logic [1:0] k);
    logic [127:0] a;
    logic [127:0] b;
    a = pat(32'h404);
    b = pat(32'h500);
    stall <= 1'b1;
    slow <= 1'b0;
    put(pat(32'h400), 1'b1, 1'b0, 2'h3);
    put(a, 1'b0, 1'b1, k);
    put(b, 1'b1, 1'b1, 2'h2);
    want(pat(32'h400), 5'h10, 5'h00);
    want({b[63:0], a[63:0]}, 5'h18, {2'h2, k[0], 2'h3});
    want({64'h0, b[127:64]}, 5'h00, 5'h13);
    fork
      send();
      begin
        repeat (8) @(negedge core_clk_i);
        chk("held tvalid", 128'h1, 128'(tvalid));
        chk("held start", 128'h10, 128'(tuser[14:10]));
        @(posedge core_clk_i);
        stall <= 1'b0;
      end
    join
    drain("straddle");
  endtask : t_straddle

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_single();
    for (int k = 0; k < 4; k++) t_multi(2'(k));
    for (int k = 0; k < 2; k++) t_straddle(2'(k));
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule : rx_tlp_stream_framing_128_tb
